// ---- bench/i2m_slave_model.sv ----
// I2C slave model: acks written bytes, sends a set byte on reads
`timescale 1ns/1ps
module i2m_slave_model (
    // Bench control
    input wire logic rst,
    input wire logic read_mode,
    input wire logic ack_en,
    input wire logic [7:0] tx_byte,
    // Wires, SDA open drain with pull-up
    input wire logic scl,
    output logic sda_rel
);
    logic [3:0] rise_cnt;
    // Clock rises in the byte; wraps after the ack clock
    always @(posedge scl or posedge rst)
        if (rst)
            rise_cnt <= 4'h0;
        else
            rise_cnt <= (rise_cnt == 4'h9) ? 4'h1 : rise_cnt + 4'h1;
    // Data moves only after SCL falls, so it is stable while high
    always @(negedge scl or posedge rst)
        if (rst)
            sda_rel <= read_mode ? tx_byte[7] : 1'b1;
        else if (read_mode)
            sda_rel <= (rise_cnt < 4'h8) ? tx_byte[3'h7 - rise_cnt[2:0]] : 1'b1;
        else
            sda_rel <= !(ack_en && rise_cnt == 4'h8);
endmodule // i2m_slave_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the I2C master engine
`timescale 1ns/1ps
`include "i2m_defs.svh"
module tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    i2m_pkg::i2m_bus_req_t req = '0;
    logic [7:0] rd_data;
    i2m_pkg::i2m_pin_drv_t pin_drv;
    logic slv_rst = 1'b0, slv_rd = 1'b0, slv_ack = 1'b1, slv_sda_rel, tb_sda_rel = 1'b1;
    logic tb_scl_rel = 1'b1;
    logic [7:0] slv_byte = 8'h00, got;
    logic [8:0] wire_cap = '0;
    int n_mismatch = 0, n_checks = 0;
    // Pull-ups on both wires
    wire scl_w = pin_drv.scl_oe_n & tb_scl_rel;
    wire sda_w = pin_drv.sda_oe_n & slv_sda_rel & tb_sda_rel;
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #12.5 core_clk = ~core_clk;
    i2m_master i2m_master_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .BUS_REQ(req),
        .RD_DATA(rd_data), .SCL_IN(scl_w), .SDA_IN(sda_w), .PIN_DRV(pin_drv));
    i2m_slave_model i2m_slave_model_i (.rst(slv_rst), .read_mode(slv_rd), .ack_en(slv_ack),
        .tx_byte(slv_byte), .scl(scl_w), .sda_rel(slv_sda_rel));
    // Last nine bits seen on the wire at SCL rises
    always @(posedge scl_w) wire_cap <= {wire_cap[7:0], sda_w};
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 got = rd_data;
    endtask
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        bus_rd(a);
        chk({1'b0, got & m}, {1'b0, e});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Polls a flag bit; bounded so a hung engine ends the run
    task automatic wait_flag(input int b);
        for (int i = 0; i < 3000; i++)
        begin
            bus_rd(`I2M_OFF_FLAGS);
            if (got[b] === 1'b1)
                return;
        end
        n_mismatch++;
        $display("[FAIL] %0t flag wait ran out", $time);
        report_and_stop();
    endtask
    // Settings land one edge before the model reset samples them
    task automatic slave_set(input logic r, input logic [7:0] b, input logic a);
        @(posedge core_clk);
        slv_rd <= r;
        slv_byte <= b;
        slv_ack <= a;
        @(posedge core_clk);
        slv_rst <= 1'b1;
        @(posedge core_clk);
        slv_rst <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(`I2M_OFF_RELOAD, 8'hFF, 8'h04);
        rd_chk(8'h20, 8'hFF, 8'h00);
        // Acked address byte, late rewrite discarded, receive refused while busy
        slave_set(1'b0, 8'h00, 1'b1);
        bus_wr(`I2M_OFF_DATA, 8'hA5);
        rd_chk(`I2M_OFF_STATUS, 8'h01, 8'h01);
        bus_wr(`I2M_OFF_CON2, 8'h08);
        rd_chk(`I2M_OFF_CON2, 8'h08, 8'h00);
        repeat (20) @(posedge core_clk);
        bus_wr(`I2M_OFF_DATA, 8'h11);
        rd_chk(`I2M_OFF_FLAGS, 8'h80, 8'h80);
        wait_flag(0);
        chk(wire_cap, {8'hA5, 1'b0});
        rd_chk(`I2M_OFF_STATUS, 8'h01, 8'h00);
        rd_chk(`I2M_OFF_CON2, 8'h40, 8'h00);
        rd_chk(`I2M_OFF_FLAGS, 8'h80, 8'h80);
        chk({8'h00, scl_w}, 9'h000);
        // Early rewrite replaces the byte; no ack
        bus_wr(`I2M_OFF_FLAGS, 8'h00);
        slave_set(1'b0, 8'h00, 1'b0);
        bus_wr(`I2M_OFF_DATA, 8'h3C);
        bus_wr(`I2M_OFF_DATA, 8'h5A);
        wait_flag(0);
        chk(wire_cap, {8'h5A, 1'b1});
        rd_chk(`I2M_OFF_FLAGS, 8'h80, 8'h80);
        rd_chk(`I2M_OFF_CON2, 8'h40, 8'h40);
        // Two receives without reading: overflow on the second
        bus_wr(`I2M_OFF_FLAGS, 8'h00);
        slave_set(1'b1, 8'h96, 1'b1);
        bus_wr(`I2M_OFF_CON2, 8'h08);
        bus_wr(`I2M_OFF_DATA, 8'h77);
        wait_flag(0);
        rd_chk(`I2M_OFF_FLAGS, 8'hC0, 8'h80);
        rd_chk(`I2M_OFF_CON2, 8'h08, 8'h00);
        rd_chk(`I2M_OFF_STATUS, 8'h01, 8'h01);
        bus_wr(`I2M_OFF_FLAGS, 8'h00);
        slave_set(1'b1, 8'h69, 1'b1);
        bus_wr(`I2M_OFF_CON2, 8'h08);
        wait_flag(0);
        rd_chk(`I2M_OFF_FLAGS, 8'h40, 8'h40);
        rd_chk(`I2M_OFF_DATA, 8'hFF, 8'h69);
        rd_chk(`I2M_OFF_STATUS, 8'h01, 8'h00);
        // Acknowledge sequence after the received byte
        bus_wr(`I2M_OFF_FLAGS, 8'h00);
        bus_wr(`I2M_OFF_CON2, 8'h10);
        wait_flag(0);
        chk({8'h00, wire_cap[0]}, 9'h000);
        rd_chk(`I2M_OFF_CON2, 8'h10, 8'h00);
        // Clean repeated start ends with both wires low
        bus_wr(`I2M_OFF_FLAGS, 8'h00);
        slave_set(1'b0, 8'h00, 1'b0);
        bus_wr(`I2M_OFF_CON2, 8'h02);
        wait_flag(0);
        rd_chk(`I2M_OFF_FLAGS, 8'h02, 8'h00);
        chk({7'h00, scl_w, sda_w}, 9'h000);
        // SCL pulled low by another master inside the hold count: collision
        bus_wr(`I2M_OFF_CON2, 8'h02);
        repeat (8) @(posedge core_clk);
        tb_scl_rel <= 1'b0;
        wait_flag(1);
        tb_scl_rel <= 1'b1;
        // SDA held low by another master: collision, lines released
        bus_wr(`I2M_OFF_FLAGS, 8'h00);
        tb_sda_rel <= 1'b0;
        bus_wr(`I2M_OFF_CON2, 8'h02);
        wait_flag(1);
        tb_sda_rel <= 1'b1;
        chk({5'h00, pin_drv}, 9'h005);
        report_and_stop();
    end
endmodule // tb_top

// ---- hw/i2m_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the I2C master engine
`ifndef I2M_DEFS_SVH
`define I2M_DEFS_SVH

// Register byte offsets
`define I2M_OFF_DATA 8'h00
`define I2M_OFF_STATUS 8'h04
`define I2M_OFF_CON2 8'h08
`define I2M_OFF_FLAGS 8'h0C
`define I2M_OFF_RELOAD 8'h10

// Status register fields
`define I2M_BIT_BF 0
// Control register 2 fields
`define I2M_BIT_RSEN 1
`define I2M_BIT_RECEIVE_ENABLE_BIT 3
`define I2M_BIT_ACK_SEQUENCE_ENABLE_BIT 4
`define I2M_BIT_ACK_DATA_BIT 5
`define I2M_BIT_ACK_STATUS_BIT 6
// Flag register fields, each cleared by writing a zero
`define I2M_BIT_PIF 0
`define I2M_BIT_BCL 1
`define I2M_BIT_OVF 6
`define I2M_BIT_WRITE_COLLISION_FLAG 7

// Reset values
`define I2M_RST_RELOAD 7'h0_04
`define I2M_RST_BYTE 8'h00

// Timing: clock period, instruction cycle, rewrite window (longest time, rounded down)
`define I2M_CLK_NS 25
`define I2M_INSTR_NS 100
`define I2M_WRITE_COLLISION_FLAG_WIN_CYC ((2 * `I2M_INSTR_NS) / `I2M_CLK_NS)

`endif

// ---- hw/i2m_master.sv ----
// I2C master engine: byte transmit, receive, acknowledge and repeated start
//
// Summary of operation
// RULE1 - Buffer write sets full flag, starts sending
// RULE2 - SDA changes after SCL falls; low, high periods
// RULE3 - Eighth fall clears full flag, releases SDA
// RULE4 - Ninth fall samples SDA into ack status
// RULE5 - After ninth clock: interrupt flag, generator stops
// RULE6 - Address: seven bits plus R/W, MSB first
// RULE7 - Full flag set by write, cleared after eight
// RULE8 - Busy write: collision; early rewrite still updates
// RULE9 - Collision flag cleared only by software
// RULE10 - Receive enable honoured only while idle
// RULE11 - Receive eight bits, store, flag, stop
// RULE12 - Reading buffer in receive clears full flag
// RULE13 - Software may then request acknowledge sequence
// RULE14 - Byte completes with full flag: overflow
// RULE15 - Write during receive: collision, buffer kept
// RULE16 - Repeated start: SDA low at SCL high collides
// RULE17 - SDA high: reload and keep counting
// RULE18 - SCL falling early before SDA low collides
// RULE19 - Expiry: SDA low, reload, then SCL low
// RULE20 - Slave acknowledges its address or data
// RULE21 - Collision: flag, release lines, go idle
`timescale 1ns/1ps
`include "i2m_defs.svh"

module i2m_master (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Register bus
    input wire i2m_pkg::i2m_bus_req_t BUS_REQ,
    output logic [7:0] RD_DATA,
    // Serial clock and data pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output i2m_pkg::i2m_pin_drv_t PIN_DRV
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    i2m_pkg::i2m_state_t state_reg;
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_s_reg;
    logic sda_s_reg;
    logic [6:0] brg_cnt_reg;
    logic [6:0] reload_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] buf_reg;
    logic [3:0] win_cnt_reg;
    logic scl_low_reg;
    logic sda_low_reg;
    logic bf_reg;
    logic ack_status_bit_reg;
    logic ack_data_bit_reg;
    logic ack_sequence_enable_bit_reg;
    logic receive_enable_bit_reg;
    logic rsen_reg;
    logic pif_reg;
    logic bcl_reg;
    logic ovf_reg;
    logic write_collision_flag_reg;
    logic [7:0] rd_next;

    // Address decode shared by every register
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic idle;
    logic in_tx;
    logic tick;
    logic wr_data;
    logic wr_con2;
    logic wr_flags;
    logic rd_data;
    logic launch;
    logic tx_rewrite;
    logic wr_busy;
    logic rsen_go;
    logic receive_enable_bit_go;
    logic ack_sequence_enable_bit_go;
    logic tx_fall;
    logic tx_clr_bf;
    logic tx_done;
    logic rx_done;
    logic ack_done;
    logic rs_done;
    logic bcl_ev;
    logic [7:0] rx_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and engine events
    assign idle = (state_reg == i2m_pkg::S_IDLE);
    assign in_tx = (state_reg == i2m_pkg::S_TX_LOW) || (state_reg == i2m_pkg::S_TX_HIGH);
    assign tick = !idle && (brg_cnt_reg == 7'h0_00);
    assign wr_data = BUS_REQ.wr && hit(BUS_REQ.addr, `I2M_OFF_DATA);
    assign wr_con2 = BUS_REQ.wr && hit(BUS_REQ.addr, `I2M_OFF_CON2);
    assign wr_flags = BUS_REQ.wr && hit(BUS_REQ.addr, `I2M_OFF_FLAGS);
    assign rd_data = BUS_REQ.rd && hit(BUS_REQ.addr, `I2M_OFF_DATA);
    assign launch = wr_data && idle; // [RULE1]
    assign tx_rewrite = wr_data && in_tx && (win_cnt_reg != 4'h0); // [RULE8]
    assign wr_busy = wr_data && !idle; // [RULE8] [RULE15]
    // Only one sequence starts per write; repeated start has priority
    assign rsen_go = wr_con2 && idle && BUS_REQ.wdata[`I2M_BIT_RSEN];
    assign receive_enable_bit_go = wr_con2 && idle && !rsen_go && BUS_REQ.wdata[`I2M_BIT_RECEIVE_ENABLE_BIT]; // [RULE10]
    assign ack_sequence_enable_bit_go = wr_con2 && idle && !rsen_go && !receive_enable_bit_go
        && BUS_REQ.wdata[`I2M_BIT_ACK_SEQUENCE_ENABLE_BIT]; // [RULE13]
    assign tx_fall = (state_reg == i2m_pkg::S_TX_HIGH) && tick;
    assign tx_clr_bf = tx_fall && (bit_cnt_reg == 4'h7); // [RULE3]
    assign tx_done = tx_fall && (bit_cnt_reg == 4'h8); // [RULE4]
    assign rx_done = (state_reg == i2m_pkg::S_RX_HIGH) && tick && (bit_cnt_reg == 4'h7);
    assign ack_done = (state_reg == i2m_pkg::S_ACK_HIGH) && tick;
    assign rs_done = (state_reg == i2m_pkg::S_RS_FINAL) && tick;
    assign rx_byte = {shift_reg[6:0], sda_s_reg};
    // SDA low at SCL high, or SCL dropping while we still hold SDA released
    assign bcl_ev = ((state_reg == i2m_pkg::S_RS_SCLHI) && scl_s_reg && !sda_s_reg) // [RULE16]
        || ((state_reg == i2m_pkg::S_RS_HOLD) && !tick && !scl_s_reg && !sda_low_reg); // [RULE18]

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_s_reg <= 1'b1;
            sda_s_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
            sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_s_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_s_reg <= sda_sync_reg[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud generator: reloads on rollover, held loaded while idle or waiting on SCL
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            brg_cnt_reg <= `I2M_RST_RELOAD;
        else if (idle || tick || (state_reg == i2m_pkg::S_RS_SCLHI)) // [RULE5] [RULE17]
            brg_cnt_reg <= reload_reg; // [RULE16]
        else
            brg_cnt_reg <= brg_cnt_reg - 7'h0_01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rewrite window after a transmit launch
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            win_cnt_reg <= 4'h0;
        else if (launch)
            win_cnt_reg <= 4'(`I2M_WRITE_COLLISION_FLAG_WIN_CYC); // [RULE8]
        else if (win_cnt_reg != 4'h0)
            win_cnt_reg <= win_cnt_reg - 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit engine: state, shifting and line drive
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_reg <= i2m_pkg::S_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= `I2M_RST_BYTE;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            ack_status_bit_reg <= 1'b0;
        end
        else if (bcl_ev)
        begin
            // Lose arbitration: let go of both lines, collision flag set
            state_reg <= i2m_pkg::S_IDLE; // [RULE21]
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                i2m_pkg::S_IDLE:
                begin
                    bit_cnt_reg <= 4'h0;
                    if (launch)
                    begin
                        shift_reg <= BUS_REQ.wdata; // [RULE6]
                        sda_low_reg <= !BUS_REQ.wdata[7];
                        scl_low_reg <= 1'b1;
                        state_reg <= i2m_pkg::S_TX_LOW;
                    end
                    else if (rsen_go)
                    begin
                        sda_low_reg <= 1'b0; // [RULE16]
                        state_reg <= i2m_pkg::S_RS_REL;
                    end
                    else if (receive_enable_bit_go)
                    begin
                        sda_low_reg <= 1'b0;
                        scl_low_reg <= 1'b1;
                        state_reg <= i2m_pkg::S_RX_LOW;
                    end
                    else if (ack_sequence_enable_bit_go)
                    begin
                        // Ack level written with the enable counts at once
                        sda_low_reg <= !BUS_REQ.wdata[`I2M_BIT_ACK_DATA_BIT];
                        scl_low_reg <= 1'b1;
                        state_reg <= i2m_pkg::S_ACK_LOW;
                    end
                end
                i2m_pkg::S_TX_LOW:
                begin
                    // Corrupting rewrite still lands in the first bit period
                    if (tx_rewrite && (bit_cnt_reg == 4'h0))
                    begin
                        shift_reg <= BUS_REQ.wdata; // [RULE8]
                        sda_low_reg <= !BUS_REQ.wdata[7];
                    end
                    if (tick)
                    begin
                        scl_low_reg <= 1'b0; // [RULE2]
                        state_reg <= i2m_pkg::S_TX_HIGH;
                    end
                end
                i2m_pkg::S_TX_HIGH:
                begin
                    if (tick)
                    begin
                        scl_low_reg <= 1'b1; // [RULE2]
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        state_reg <= i2m_pkg::S_TX_LOW;
                        if (bit_cnt_reg == 4'h8)
                        begin
                            ack_status_bit_reg <= sda_s_reg; // [RULE4]
                            state_reg <= i2m_pkg::S_IDLE; // [RULE5]
                        end
                        else if (bit_cnt_reg == 4'h7)
                            sda_low_reg <= 1'b0; // [RULE3]
                        else
                        begin
                            sda_low_reg <= !shift_reg[6]; // [RULE6]
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                i2m_pkg::S_RX_LOW:
                begin
                    if (tick)
                    begin
                        scl_low_reg <= 1'b0; // [RULE11]
                        state_reg <= i2m_pkg::S_RX_HIGH;
                    end
                end
                i2m_pkg::S_RX_HIGH:
                begin
                    if (tick)
                    begin
                        shift_reg <= rx_byte; // [RULE11]
                        scl_low_reg <= 1'b1;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        state_reg <= (bit_cnt_reg == 4'h7) ? i2m_pkg::S_IDLE
                            : i2m_pkg::S_RX_LOW;
                    end
                end
                i2m_pkg::S_ACK_LOW:
                begin
                    if (tick)
                    begin
                        scl_low_reg <= 1'b0;
                        state_reg <= i2m_pkg::S_ACK_HIGH;
                    end
                end
                i2m_pkg::S_ACK_HIGH:
                begin
                    if (tick)
                    begin
                        scl_low_reg <= 1'b1;
                        sda_low_reg <= 1'b0;
                        state_reg <= i2m_pkg::S_IDLE;
                    end
                end
                i2m_pkg::S_RS_REL:
                begin
                    if (tick)
                    begin
                        scl_low_reg <= 1'b0; // [RULE16]
                        state_reg <= i2m_pkg::S_RS_SCLHI;
                    end
                end
                i2m_pkg::S_RS_SCLHI:
                begin
                    // Generator held loaded until SCL is seen high
                    if (scl_s_reg)
                        state_reg <= i2m_pkg::S_RS_HOLD; // [RULE17]
                end
                i2m_pkg::S_RS_HOLD:
                begin
                    // SDA pulled low by another master here is no collision
                    if (tick)
                    begin
                        sda_low_reg <= 1'b1; // [RULE19]
                        state_reg <= i2m_pkg::S_RS_FINAL;
                    end
                end
                i2m_pkg::S_RS_FINAL:
                begin
                    if (tick)
                    begin
                        scl_low_reg <= 1'b1; // [RULE19]
                        state_reg <= i2m_pkg::S_IDLE;
                    end
                end
                default:
                    state_reg <= i2m_pkg::S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data buffer: software write or received byte
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            buf_reg <= `I2M_RST_BYTE;
        else if (rx_done)
            buf_reg <= rx_byte; // [RULE11]
        else if (launch || tx_rewrite)
            buf_reg <= BUS_REQ.wdata; // [RULE8]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer-full flag; a set in the same cycle as a clear wins
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            bf_reg <= 1'b0;
        else if (launch || tx_rewrite || rx_done)
            bf_reg <= 1'b1; // [RULE1] [RULE7] [RULE11]
        else if (tx_clr_bf || (rd_data && !in_tx))
            bf_reg <= 1'b0; // [RULE7] [RULE12]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register 2 and reload register
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ack_data_bit_reg <= 1'b0;
            ack_sequence_enable_bit_reg <= 1'b0;
            receive_enable_bit_reg <= 1'b0;
            rsen_reg <= 1'b0;
            reload_reg <= `I2M_RST_RELOAD;
        end
        else
        begin
            if (wr_con2)
                ack_data_bit_reg <= BUS_REQ.wdata[`I2M_BIT_ACK_DATA_BIT];
            if (BUS_REQ.wr && hit(BUS_REQ.addr, `I2M_OFF_RELOAD))
                reload_reg <= BUS_REQ.wdata[6:0];
            // Start bits only take while idle, drop when their sequence ends
            if (rsen_go)
                rsen_reg <= 1'b1;
            else if (rs_done || bcl_ev)
                rsen_reg <= 1'b0; // [RULE21]
            if (receive_enable_bit_go)
                receive_enable_bit_reg <= 1'b1; // [RULE10]
            else if (rx_done)
                receive_enable_bit_reg <= 1'b0; // [RULE11]
            if (ack_sequence_enable_bit_go)
                ack_sequence_enable_bit_reg <= 1'b1;
            else if (ack_done)
                ack_sequence_enable_bit_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event flags; only a software zero write clears them, a set wins
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pif_reg <= 1'b0;
            bcl_reg <= 1'b0;
            ovf_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
        end
        else
        begin
            if (tx_done || rx_done || ack_done || rs_done)
                pif_reg <= 1'b1; // [RULE5] [RULE11]
            else if (wr_flags && !BUS_REQ.wdata[`I2M_BIT_PIF])
                pif_reg <= 1'b0;
            if (bcl_ev)
                bcl_reg <= 1'b1; // [RULE21]
            else if (wr_flags && !BUS_REQ.wdata[`I2M_BIT_BCL])
                bcl_reg <= 1'b0;
            if (rx_done && bf_reg)
                ovf_reg <= 1'b1; // [RULE14]
            else if (wr_flags && !BUS_REQ.wdata[`I2M_BIT_OVF])
                ovf_reg <= 1'b0;
            if (wr_busy)
                write_collision_flag_reg <= 1'b1; // [RULE8] [RULE15]
            else if (wr_flags && !BUS_REQ.wdata[`I2M_BIT_WRITE_COLLISION_FLAG])
                write_collision_flag_reg <= 1'b0; // [RULE9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped reads give zero
    always_comb
    begin
        rd_next = 8'h00;
        if (hit(BUS_REQ.addr, `I2M_OFF_DATA))
            rd_next = buf_reg;
        if (hit(BUS_REQ.addr, `I2M_OFF_STATUS))
            rd_next[`I2M_BIT_BF] = bf_reg;
        if (hit(BUS_REQ.addr, `I2M_OFF_CON2))
        begin
            rd_next[`I2M_BIT_RSEN] = rsen_reg;
            rd_next[`I2M_BIT_RECEIVE_ENABLE_BIT] = receive_enable_bit_reg;
            rd_next[`I2M_BIT_ACK_SEQUENCE_ENABLE_BIT] = ack_sequence_enable_bit_reg;
            rd_next[`I2M_BIT_ACK_DATA_BIT] = ack_data_bit_reg;
            rd_next[`I2M_BIT_ACK_STATUS_BIT] = ack_status_bit_reg;
        end
        if (hit(BUS_REQ.addr, `I2M_OFF_FLAGS))
        begin
            rd_next[`I2M_BIT_PIF] = pif_reg;
            rd_next[`I2M_BIT_BCL] = bcl_reg;
            rd_next[`I2M_BIT_OVF] = ovf_reg;
            rd_next[`I2M_BIT_WRITE_COLLISION_FLAG] = write_collision_flag_reg;
        end
        if (hit(BUS_REQ.addr, `I2M_OFF_RELOAD))
            rd_next = {1'b0, reload_reg};
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            RD_DATA <= 8'h00;
        else if (BUS_REQ.rd)
            RD_DATA <= rd_next;
        else
            RD_DATA <= 8'h00;
    end

    // Open-drain drive: outputs stay low, enable low pulls the line
    assign PIN_DRV.scl_out = 1'b0;
    assign PIN_DRV.sda_out = 1'b0;
    assign PIN_DRV.scl_oe_n = !scl_low_reg;
    assign PIN_DRV.sda_oe_n = !sda_low_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    tx_launch_a: assert property (launch |=> bf_reg && state_reg == i2m_pkg::S_TX_LOW) // [RULE1]
        else $error("buffer write did not launch transmit");
    scl_phase_a: assert property (tx_fall |=> scl_low_reg && state_reg != i2m_pkg::S_TX_HIGH) // [RULE2]
        else $error("SCL not pulled low at end of high phase");
    eighth_fall_a: assert property (tx_clr_bf |=> !bf_reg && !sda_low_reg) // [RULE3]
        else $error("eighth fall did not clear full flag and release SDA");
    ack_sample_a: assert property (tx_done |=> ack_status_bit_reg == $past(sda_s_reg)) // [RULE4]
        else $error("ack status does not match sampled SDA");
    tx_stop_a: assert property (tx_done |=> (pif_reg && idle && scl_low_reg) [*2]) // [RULE5]
        else $error("engine did not stop with SCL low");
    write_collision_flag_hold_a: assert property (write_collision_flag_reg && !wr_flags |=> write_collision_flag_reg) // [RULE9]
        else $error("write collision flag cleared by itself");
    receive_enable_bit_ignore_a: assert property (wr_con2 && !idle |=> $stable(receive_enable_bit_reg) || !receive_enable_bit_reg) // [RULE10]
        else $error("receive enable taken while busy");
    rx_end_a: assert property (rx_done |=> !receive_enable_bit_reg && bf_reg && pif_reg && idle) // [RULE11]
        else $error("receive completion wrong");
    rx_ovf_a: assert property (rx_done && bf_reg |=> ovf_reg) // [RULE14]
        else $error("overflow not flagged");
    bcl_release_a: assert property (bcl_ev |=> bcl_reg && idle && !scl_low_reg && !sda_low_reg) // [RULE21]
        else $error("collision did not release the bus");

    tx_byte_c: cover property (tx_done);
    rx_byte_c: cover property (rx_done);
    rs_done_c: cover property (rs_done);
    bcl_c: cover property (bcl_ev);

endmodule // i2m_master

// ---- hw/i2m_pkg.sv ----
// Types shared by the I2C master engine
package i2m_pkg;

    // Engine states
    typedef enum logic [3:0] {
        S_IDLE, S_TX_LOW, S_TX_HIGH, S_RX_LOW, S_RX_HIGH,
        S_ACK_LOW, S_ACK_HIGH, S_RS_REL, S_RS_SCLHI, S_RS_HOLD, S_RS_FINAL
    } i2m_state_t;

    // One register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } i2m_bus_req_t;

    // Open-drain pin drive, enables active low
    typedef struct packed {
        logic scl_out;
        logic scl_oe_n;
        logic sda_out;
        logic sda_oe_n;
    } i2m_pin_drv_t;

endpackage
